// >>> eii_pkg.sv
// shared constants and types for the external interrupt input block
package eii_pkg;

	// ************************************************************
	// register map (byte addresses, one 32-bit word each)
	// ************************************************************
	localparam logic [11:0] CTRL_OFF = 12'h000;
	localparam logic [11:0] PEND_OFF = 12'h004;
	localparam logic [11:0] STAT_OFF = 12'h008;
	localparam logic [11:0] MASK_OFF = 12'h00C;

	// ************************************************************
	// field positions and reset values
	// ************************************************************
	localparam int CTRL_W = 7;
	localparam int STAT_W = 5;
	localparam int STAT_NMI_BIT = 0;
	localparam int STAT_REQ_LSB = 1;
	localparam int PEND_NMI_BIT = 4;
	localparam logic [6:0] CTRL_RST = 7'h00;
	localparam logic [4:0] STAT_RST = 5'h00;
	localparam logic [4:0] MASK_RST = 5'h00;

	// vector type raised for the non-maskable request
	localparam logic [7:0] NMI_TYPE = 8'h02;

	// control word: pin roles and trigger mode of each request
	typedef struct packed {
		logic slave;
		logic ack_d;
		logic ack_c;
		logic [3:0] trig_edge;
	} eii_ctrl_s;

	// one two-way pin as seen by the design
	typedef struct packed {
		logic o;
		logic oe;
	} eii_pin_s;

endpackage : eii_pkg

// >>> eii_top.sv
// external interrupt inputs: nmi latch, four maskable requests, ack and slave pin roles
`timescale 1ns/10ps
module eii_top #(
	parameter int ADDR_W = 12
) (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic clk_en_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [ADDR_W-1:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// pins
	input wire logic nmi_pin_i,
	input wire logic irq_pin_a_i,
	input wire logic irq_pin_b_i,
	input wire logic irq_pin_c_i,
	output logic irq_pin_c_o,
	output logic irq_pin_c_oe_o,
	input wire logic irq_pin_d_i,
	output logic irq_pin_d_o,
	output logic irq_pin_d_oe_o,
	// core side
	input wire logic instr_boundary_i,
	input wire logic core_ack_i,
	input wire logic [1:0] core_ack_id_i,
	output logic nmi_take_o,
	output logic [7:0] nmi_vector_o,
	output logic [3:0] irq_pending_o,
	output logic slave_select_o,
	output logic irq_o
);

	// ************************************************************
	// registers and internal signals
	// ************************************************************
	eii_pkg::eii_ctrl_s ctrl;
	logic [eii_pkg::STAT_W-1:0] stat;
	logic [eii_pkg::STAT_W-1:0] mask;
	logic nmi_s1;
	logic nmi_s2;
	logic nmi_prev;
	logic nmi_pend;
	logic nmi_rise;
	logic nmi_take;
	logic [3:0] req_s1;
	logic [3:0] req_s2;
	logic [3:0] req_prev;
	logic [3:0] req_en;
	logic [3:0] req_rise;
	logic [3:0] edge_pend;
	logic [3:0] pend_now;
	logic [3:0] ack_hit;
	logic [eii_pkg::STAT_W-1:0] events;
	logic [eii_pkg::STAT_W-1:0] stat_clr;
	logic acc;
	logic wr_done;
	logic [31:0] next_rdata;
	logic next_err;
	eii_pkg::eii_pin_s next_pin_c;
	eii_pkg::eii_pin_s next_pin_d;
	logic [2:0] oe_c_trail;
	logic [2:0] oe_d_trail;

	// address match against a register word
	function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [11:0] off);
		reg_hit = (addr == ADDR_W'(off));
	endfunction : reg_hit

	// ************************************************************
	// pin synchronisers
	// ************************************************************
	// nmi two-flop sync
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			nmi_s1 <= 1'b0;
			nmi_s2 <= 1'b0;
			nmi_prev <= 1'b0;
		end else if (clk_en_i) begin
			nmi_s1 <= nmi_pin_i;
			nmi_s2 <= nmi_s1;
			nmi_prev <= nmi_s2;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			req_s1 <= 4'h0;
			req_s2 <= 4'h0;
			req_prev <= 4'h0;
		end else if (clk_en_i) begin
			req_s1 <= {irq_pin_d_i, irq_pin_c_i, irq_pin_b_i, irq_pin_a_i};
			req_s2 <= req_s1;
			req_prev <= req_s2;
		end
	end

	// a pin turned back to input still shows its own drive in the sync
	// stages for three edges; its request stays off until that has drained
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			oe_c_trail <= 3'h0;
			oe_d_trail <= 3'h0;
		end else if (clk_en_i) begin
			oe_c_trail <= {oe_c_trail[1:0], irq_pin_c_oe_o};
			oe_d_trail <= {oe_d_trail[1:0], irq_pin_d_oe_o};
		end
	end

	// ************************************************************
	// non-maskable request
	// ************************************************************
	// rising edge detect
	assign nmi_rise = nmi_s2 & ~nmi_prev;
	assign nmi_take = nmi_pend & instr_boundary_i;

	// latch has no mask; a new edge during take stays pending
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			nmi_pend <= 1'b0;
			nmi_take_o <= 1'b0;
			nmi_vector_o <= 8'h00;
		end else if (clk_en_i) begin
			nmi_pend <= nmi_rise | (nmi_pend & ~nmi_take);
			nmi_take_o <= nmi_take;
			if (nmi_take) begin
				nmi_vector_o <= eii_pkg::NMI_TYPE;
			end
		end
	end

	// ************************************************************
	// maskable requests
	// ************************************************************
	// pin roles decide which inputs still request
	always_comb begin
		req_en[0] = 1'b1;
		req_en[1] = ~ctrl.slave;
		req_en[2] = ~ctrl.ack_c & ~irq_pin_c_oe_o & ~(|oe_c_trail);
		req_en[3] = ~ctrl.ack_d & ~ctrl.slave & ~irq_pin_d_oe_o & ~(|oe_d_trail);
	end

	assign req_rise = req_s2 & ~req_prev & req_en;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_req
			assign ack_hit[gi] = core_ack_i & (core_ack_id_i == 2'(gi));
			assign pend_now[gi] = ctrl.trig_edge[gi] ? edge_pend[gi] : (req_s2[gi] & req_en[gi]);

			// edge held until acknowledge or until req_en drops, set wins
			always_ff @(posedge ref_clk_i) begin
				if (sys_rst_i) begin
					edge_pend[gi] <= 1'b0;
				end else if (clk_en_i) begin
					edge_pend[gi] <= req_rise[gi] | (edge_pend[gi] & ~ack_hit[gi] & req_en[gi]);
				end
			end
		end
	endgenerate

	// pending view toward the core
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			irq_pending_o <= 4'h0;
		end else if (clk_en_i) begin
			irq_pending_o <= pend_now;
		end
	end

	// ************************************************************
	// two-way pins c and d
	// ************************************************************
	// ack pulse on c for request a, on d for request b
	always_comb begin
		next_pin_c.oe = ctrl.ack_c;
		next_pin_c.o = ~(ctrl.ack_c & ack_hit[0]);
		next_pin_d.oe = ctrl.ack_d | ctrl.slave;
		// slave mode forwards any pending request to the master
		if (ctrl.slave) begin
			next_pin_d.o = |pend_now;
		end else begin
			next_pin_d.o = ~(ctrl.ack_d & ack_hit[1]);
		end
	end

	// pins idle high and undriven from reset
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			irq_pin_c_o <= 1'b1;
			irq_pin_c_oe_o <= 1'b0;
			irq_pin_d_o <= 1'b1;
			irq_pin_d_oe_o <= 1'b0;
			slave_select_o <= 1'b0;
		end else if (clk_en_i) begin
			irq_pin_c_o <= next_pin_c.o;
			irq_pin_c_oe_o <= next_pin_c.oe;
			irq_pin_d_o <= next_pin_d.o;
			irq_pin_d_oe_o <= next_pin_d.oe;
			slave_select_o <= ctrl.slave & req_s2[1];
		end
	end

	// ************************************************************
	// apb slave
	// ************************************************************
	// one wait state: pready rises the cycle after the access phase starts
	assign acc = psel_i & penable_i & ~pready_o;
	assign wr_done = psel_i & penable_i & pready_o & pwrite_i;

	// read mux and unmapped detect
	always_comb begin
		next_rdata = 32'h0000_0000;
		next_err = 1'b0;
		if (reg_hit(paddr_i, eii_pkg::CTRL_OFF)) begin
			next_rdata[eii_pkg::CTRL_W-1:0] = ctrl;
		end else if (reg_hit(paddr_i, eii_pkg::PEND_OFF)) begin
			next_rdata[3:0] = pend_now;
			next_rdata[eii_pkg::PEND_NMI_BIT] = nmi_pend;
		end else if (reg_hit(paddr_i, eii_pkg::STAT_OFF)) begin
			next_rdata[eii_pkg::STAT_W-1:0] = stat;
		end else if (reg_hit(paddr_i, eii_pkg::MASK_OFF)) begin
			next_rdata[eii_pkg::STAT_W-1:0] = mask;
		end else begin
			next_err = 1'b1;
		end
	end

	// handshake and read data
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o <= 32'h0000_0000;
		end else if (clk_en_i) begin
			pready_o <= acc;
			pslverr_o <= acc & next_err;
			if (acc && !pwrite_i) begin
				prdata_o <= next_rdata;
			end
		end
	end

	// control and mask writes land on the completing edge
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			ctrl <= eii_pkg::CTRL_RST;
			mask <= eii_pkg::MASK_RST;
		end else if (clk_en_i && wr_done) begin
			if (reg_hit(paddr_i, eii_pkg::CTRL_OFF)) begin
				ctrl <= pwdata_i[eii_pkg::CTRL_W-1:0];
			end
			if (reg_hit(paddr_i, eii_pkg::MASK_OFF)) begin
				mask <= pwdata_i[eii_pkg::STAT_W-1:0];
			end
		end
	end

	// ************************************************************
	// event status and interrupt line
	// ************************************************************
	always_comb begin
		events = '0;
		events[eii_pkg::STAT_NMI_BIT] = nmi_rise;
		events[eii_pkg::STAT_REQ_LSB +: 4] = req_rise;
		stat_clr = '0;
		if (wr_done && reg_hit(paddr_i, eii_pkg::STAT_OFF)) begin
			stat_clr = pwdata_i[eii_pkg::STAT_W-1:0];
		end
	end

	// write one to clear; a fresh event beats the clear
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			stat <= eii_pkg::STAT_RST;
			irq_o <= 1'b0;
		end else if (clk_en_i) begin
			stat <= events | (stat & ~stat_clr);
			irq_o <= |(stat & mask);
		end
	end

endmodule : eii_top

// >>> eii_src_model.sv
// external request sources facing the interrupt pins
`timescale 1ns/10ps
module eii_src_model (
	input wire logic ref_clk_i,
	input wire logic [3:0] raise_i,
	input wire logic drop_i,
	input wire logic nmi_go_i,
	input wire logic core_ack_i,
	input wire logic [1:0] core_ack_id_i,
	output logic nmi_o,
	output logic [3:0] req_o = 4'h0
);
	logic [1:0] nmi_cnt = 2'h0;
	// hold until acknowledged
	// drop_i breaks this on purpose, to show what edge capture keeps
	always_ff @(posedge ref_clk_i) begin
		for (int i = 0; i < 4; i++) begin
			if (raise_i[i])
				req_o[i] <= 1'b1;
			else if (drop_i || (core_ack_i && core_ack_id_i == 2'(i)))
				req_o[i] <= 1'b0;
		end
	end
	always_ff @(posedge ref_clk_i) begin
		if (nmi_go_i)
			nmi_cnt <= 2'h2;
		else if (nmi_o)
			nmi_cnt <= nmi_cnt - 2'h1;
	end
	assign nmi_o = nmi_cnt != 2'h0;
endmodule : eii_src_model

// >>> eii_top_assertions.sv
// port checks for the external interrupt block
`timescale 1ns/10ps
module eii_top_assertions (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pready_o,
	input wire logic instr_boundary_i,
	input wire logic nmi_pin_i,
	input wire logic core_ack_i,
	input wire logic [1:0] core_ack_id_i,
	input wire logic nmi_take_o,
	input wire logic [7:0] nmi_vector_o,
	input wire logic irq_pin_c_o,
	input wire logic irq_pin_c_oe_o,
	input wire logic irq_pin_d_oe_o,
	input wire logic slave_select_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);
	// one wait state, then a single ready pulse
	property p_wait; psel_i && penable_i && !pready_o |=> pready_o; endproperty
	a_wait: assert property (p_wait) else $error("ready late");
	property p_once; pready_o |=> !pready_o; endproperty
	a_once: assert property (p_once) else $error("ready held");
	property p_vec; nmi_take_o |=> nmi_vector_o == eii_pkg::NMI_TYPE; endproperty
	a_vec: assert property (p_vec) else $error("bad vector");
	property p_pulse; nmi_take_o |=> !nmi_take_o; endproperty
	a_pulse: assert property (p_pulse) else $error("take held");
	property p_bnd; nmi_take_o |-> $past(instr_boundary_i); endproperty
	a_bnd: assert property (p_bnd) else $error("take off boundary");
	// nothing can mask it, so boundaries alone bound the delay
	property p_nmi; $rose(nmi_pin_i) ##0 instr_boundary_i[*4] |-> ##[0:4] nmi_take_o; endproperty
	a_nmi: assert property (p_nmi) else $error("nmi lost");
	property p_ackc; !irq_pin_c_o |-> irq_pin_c_oe_o && $past(core_ack_i)
		&& $past(core_ack_id_i) == 2'h0; endproperty
	a_ackc: assert property (p_ackc) else $error("stray ack c");
	property p_slv; slave_select_o |-> irq_pin_d_oe_o; endproperty
	a_slv: assert property (p_slv) else $error("slave pin d idle");
endmodule : eii_top_assertions
bind eii_top eii_top_assertions i_chk (.*);

// >>> eii_top_bench.sv
// self-checking bench for the external interrupt block
`timescale 1ns/10ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin n_fail++; $display("mismatch %s exp %0h got %0h", n, e, s); end end
module eii_top_bench;
	logic ref_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, bnd = 1'b0, ack = 1'b0, drop = 1'b0, go = 1'b0;
	logic [11:0] padr = 12'h000;
	logic [31:0] pwd = 32'h0, prd, rd;
	logic [1:0] ack_id = 2'h0;
	logic [3:0] raise = 4'h0, req, pend;
	logic pry, perr, er, nmi, c_o, c_oe, d_o, d_oe, take, ssel, irq;
	logic [7:0] vec;
	int n_fail = 0, compares = 0;
	int n_take = 0;
	// table rows: direction, address, read data and error expected
	logic t_w [6] = '{0, 0, 0, 0, 1, 0};
	logic [11:0] t_a [6] = '{eii_pkg::CTRL_OFF, eii_pkg::PEND_OFF, eii_pkg::STAT_OFF,
		eii_pkg::MASK_OFF, 12'h010, 12'h010};
	logic [31:0] t_r [6] = '{32'(eii_pkg::CTRL_RST), 32'h0, 32'(eii_pkg::STAT_RST),
		32'(eii_pkg::MASK_RST), 32'h0, 32'h0};
	logic t_e [6] = '{0, 0, 0, 0, 1, 1};
	always #50 ref_clk_i = ~ref_clk_i;
	// pins c and d resolve between the block and the sources
	eii_top i_dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(1'b1), .psel_i(psel),
		.penable_i(pen), .pwrite_i(pwr), .paddr_i(padr), .pwdata_i(pwd), .prdata_o(prd),
		.pready_o(pry), .pslverr_o(perr), .nmi_pin_i(nmi), .irq_pin_a_i(req[0]),
		.irq_pin_b_i(req[1]), .irq_pin_c_i(c_oe ? c_o : req[2]), .irq_pin_c_o(c_o),
		.irq_pin_c_oe_o(c_oe), .irq_pin_d_i(d_oe ? d_o : req[3]), .irq_pin_d_o(d_o),
		.irq_pin_d_oe_o(d_oe), .instr_boundary_i(bnd), .core_ack_i(ack), .core_ack_id_i(ack_id),
		.nmi_take_o(take), .nmi_vector_o(vec), .irq_pending_o(pend), .slave_select_o(ssel),
		.irq_o(irq));
	eii_src_model i_src (.ref_clk_i(ref_clk_i), .raise_i(raise), .drop_i(drop), .nmi_go_i(go),
		.core_ack_i(ack), .core_ack_id_i(ack_id), .nmi_o(nmi), .req_o(req));
	task close_out;
		$display("counts: %0d compares, %0d mismatches", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : close_out
	// apb transfer; a slave that never answers ends the run
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk_i);
		psel <= 1'b1;
		pwr <= w;
		padr <= a;
		pwd <= d;
		@(posedge ref_clk_i);
		pen <= 1'b1;
		do begin
			@(posedge ref_clk_i);
			n++;
		end while (pry !== 1'b1 && n < 20);
		if (pry !== 1'b1) begin
			n_fail++;
			close_out;
		end
		rd = prd;
		er = perr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb
	// one-cycle pulses toward the sources and the core side
	task kick(input logic [3:0] r, input logic dr, input logic g, input logic a, input logic [1:0] id);
		@(posedge ref_clk_i);
		raise <= r;
		drop <= dr;
		go <= g;
		ack <= a;
		ack_id <= id;
		@(posedge ref_clk_i);
		{raise, drop, go, ack} <= 7'h00;
	endtask : kick
	// long enough for two sync stages, capture and the output register
	task settle;
		repeat (6) @(posedge ref_clk_i);
	endtask : settle
	// counts nmi take pulses over eight edges, each looked at while it stands
	task count_take;
		n_take = 0;
		repeat (8) begin
			@(posedge ref_clk_i);
			if (take === 1'b1)
				n_take++;
		end
	endtask : count_take
	initial begin
		repeat (4) @(posedge ref_clk_i);
		sys_rst_i <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			apb(t_w[i], t_a[i], 32'hFFFFFFFF);
			`CHK("err", t_e[i], er)
			if (!t_w[i]) `CHK("rdata", t_r[i], rd)
		end
		$display("done: table");
		kick(4'h1, 0, 0, 0, 2'h0);
		settle;
		`CHK("level on", 4'h1, pend)
		kick(4'h0, 1, 0, 0, 2'h0);
		settle;
		`CHK("level off", 4'h0, pend)
		apb(1, eii_pkg::CTRL_OFF, 32'h0F);
		kick(4'h1, 0, 0, 0, 2'h0);
		settle;
		kick(4'h0, 1, 0, 0, 2'h0);
		settle;
		`CHK("edge kept", 4'h1, pend)
		kick(4'h0, 0, 0, 1, 2'h0);
		settle;
		`CHK("edge acked", 4'h0, pend)
		$display("done: trigger modes");
		`CHK("irq masked", 1'b0, irq)
		apb(1, eii_pkg::MASK_OFF, 32'h02);
		settle;
		`CHK("irq on", 1'b1, irq)
		apb(1, eii_pkg::STAT_OFF, 32'h02);
		settle;
		`CHK("irq cleared", 1'b0, irq)
		$display("done: interrupt");
		kick(4'h0, 0, 1, 0, 2'h0);
		settle;
		`CHK("no boundary", 1'b0, take)
		apb(0, eii_pkg::PEND_OFF, 32'h0);
		`CHK("nmi latched", 32'h10, rd)
		bnd <= 1'b1;
		count_take;
		`CHK("take pulses", 1, n_take)
		`CHK("vector", eii_pkg::NMI_TYPE, vec)
		apb(0, eii_pkg::PEND_OFF, 32'h0);
		`CHK("nmi taken", 32'h0, rd)
		// a fresh edge while boundaries keep coming is taken exactly once
		kick(4'h0, 0, 1, 0, 2'h0);
		count_take;
		`CHK("take again", 1, n_take)
		bnd <= 1'b0;
		$display("done: nmi");
		apb(1, eii_pkg::CTRL_OFF, 32'h30);
		kick(4'h0, 0, 0, 1, 2'h0);
		@(posedge ref_clk_i);
		`CHK("ack c", 2'b10, {c_oe, c_o})
		kick(4'h0, 0, 0, 1, 2'h1);
		@(posedge ref_clk_i);
		`CHK("ack d", 2'b10, {d_oe, d_o})
		$display("done: ack pins");
		apb(1, eii_pkg::CTRL_OFF, 32'h40);
		kick(4'h2, 0, 0, 0, 2'h0);
		settle;
		`CHK("slave pins", 4'hC, {ssel, d_oe, d_o, pend[1]})
		kick(4'h1, 0, 0, 0, 2'h0);
		settle;
		`CHK("slave req out", 1'b1, d_o)
		kick(4'h0, 1, 0, 0, 2'h0);
		$display("done: slave");
		sys_rst_i <= 1'b1;
		repeat (2) @(posedge ref_clk_i);
		sys_rst_i <= 1'b0;
		`CHK("reset pin c", 2'b10, {c_o, c_oe})
		`CHK("reset pin d", 2'b10, {d_o, d_oe})
		`CHK("reset outs", 7'h00, {take, irq, ssel, pend})
		apb(0, eii_pkg::CTRL_OFF, 32'h0);
		`CHK("reset ctrl", 32'h0, rd)
		$display("done: reset");
		close_out;
	end
endmodule : eii_top_bench
